// File: rtl/ewr_map.vh
`ifndef EWR_MAP_VH
`define EWR_MAP_VH
// register offsets on the configuration bus
`define CTRL_OFF        8'h00
`define STAT_OFF        8'h04
`define STALL_OFF       8'h08
// control fields and reset value
`define CTRL_EARLY_BIT  0
`define CTRL_RST        1'h1
// status fields
`define STAT_CNT_LSB    0
`define STAT_LATE_BIT   8
`define STAT_OWO_BIT    9
`define STAT_MCA_BIT    10
`define STAT_BUSY_BIT   11
// response codes
`define RESP_OKAY       2'h0
`define RESP_EXOKAY     2'h1
`define RESP_DECERR     2'h3
// cache attribute fields
`define CACHE_BUF_BIT   0
`define CACHE_MOD_BIT   1
// defaults
`define QLOG2_DEF       2
`define REGION_SHIFT_DEF 12
`define OWO_DEF         1'h0
`define MCA_VAL         1'h1
`endif

// File: rtl/wq_mem.v
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// posted write store, registered read port
module wq_mem #(
  parameter WIDTH = 8,
  parameter ALOG2 = 2
)(
  // clock
  input  wire             aclk,
  // write port
  input  wire             we,
  input  wire [ALOG2-1:0] waddr,
  input  wire [WIDTH-1:0] wdata,
  // read port
  input  wire [ALOG2-1:0] raddr,
  output reg  [WIDTH-1:0] rdata
);
  // storage array
  reg [WIDTH-1:0] mem [0:(1<<ALOG2)-1];
  // write and registered read
  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: rtl/early_wr_buffer.v
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "ewr_map.vh"
module early_wr_buffer #(
  parameter ID_W         = 4,
  parameter AW           = 32,
  parameter DW           = 32,
  parameter QLOG2        = `QLOG2_DEF,
  parameter REGION_SHIFT = `REGION_SHIFT_DEF,
  parameter OWO          = `OWO_DEF
)(
  // clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // upstream write address
  input  wire              s_awvalid,
  output reg               s_awready,
  input  wire [ID_W-1:0]   s_awid,
  input  wire [AW-1:0]     s_awaddr,
  input  wire [2:0]        s_awsize,
  input  wire [3:0]        s_awcache,
  input  wire              s_awlock,
  // upstream write data
  input  wire              s_wvalid,
  output reg               s_wready,
  input  wire [DW-1:0]     s_wdata,
  input  wire [DW/8-1:0]   s_wstrb,
  // upstream write response
  output reg               s_bvalid,
  input  wire              s_bready,
  output reg  [ID_W-1:0]   s_bid,
  output reg  [1:0]        s_bresp,
  // upstream read address
  input  wire              s_arvalid,
  output reg               s_arready,
  input  wire [ID_W-1:0]   s_arid,
  input  wire [AW-1:0]     s_araddr,
  input  wire [2:0]        s_arsize,
  input  wire [3:0]        s_arcache,
  input  wire              s_arlock,
  // upstream read data
  output reg               s_rvalid,
  input  wire              s_rready,
  output reg  [ID_W-1:0]   s_rid,
  output reg  [DW-1:0]     s_rdata,
  output reg  [1:0]        s_rresp,
  output reg               s_rlast,
  // downstream write address and data
  output reg               m_awvalid,
  input  wire              m_awready,
  output reg  [ID_W-1:0]   m_awid,
  output reg  [AW-1:0]     m_awaddr,
  output reg  [2:0]        m_awsize,
  output reg  [3:0]        m_awcache,
  output reg               m_wvalid,
  input  wire              m_wready,
  output reg  [DW-1:0]     m_wdata,
  output reg  [DW/8-1:0]   m_wstrb,
  // downstream write response
  input  wire              m_bvalid,
  output reg               m_bready,
  input  wire [1:0]        m_bresp,
  // downstream read
  output reg               m_arvalid,
  input  wire              m_arready,
  output reg  [ID_W-1:0]   m_arid,
  output reg  [AW-1:0]     m_araddr,
  output reg  [2:0]        m_arsize,
  output reg  [3:0]        m_arcache,
  input  wire              m_rvalid,
  output reg               m_rready,
  input  wire [DW-1:0]     m_rdata,
  input  wire [1:0]        m_rresp,
  // configuration bus, axi4-lite
  input  wire              cfg_awvalid,
  output reg               cfg_awready,
  input  wire [7:0]        cfg_awaddr,
  input  wire              cfg_wvalid,
  output reg               cfg_wready,
  input  wire [31:0]       cfg_wdata,
  input  wire [3:0]        cfg_wstrb,
  output reg               cfg_bvalid,
  input  wire              cfg_bready,
  output reg  [1:0]        cfg_bresp,
  input  wire              cfg_arvalid,
  output reg               cfg_arready,
  input  wire [7:0]        cfg_araddr,
  output reg               cfg_rvalid,
  input  wire              cfg_rready,
  output reg  [31:0]       cfg_rdata,
  output reg  [1:0]        cfg_rresp
);
  ////////////////////////////////////////////////////////////////////////////
  // sizes and entry layout
  localparam DEPTH = 1 << QLOG2;
  localparam NID   = 1 << ID_W;
  localparam SW    = DW / 8;
  localparam O_D   = AW;
  localparam O_S   = O_D + DW;
  localparam O_C   = O_S + SW;
  localparam O_Z   = O_C + 4;
  localparam O_I   = O_Z + 3;
  localparam O_X   = O_I + ID_W;
  localparam O_L   = O_X + 1;
  localparam EW    = O_L + 1;
  // issue states
  localparam F_IDLE = 2'h0;
  localparam F_LOAD = 2'h1;
  localparam F_SEND = 2'h2;
  localparam F_WAIT = 2'h3;
  // read states
  localparam R_IDLE = 2'h0;
  localparam R_ADDR = 2'h1;
  localparam R_DATA = 2'h2;
  localparam R_RESP = 2'h3;

  // last byte of a beat, inside its size-aligned window
  function [AW-1:0] last_byte;
    input [AW-1:0] a;
    input [2:0]    sz;
    begin
      last_byte = a | ((({{(AW-1){1'b0}}, 1'b1}) << sz) - {{(AW-1){1'b0}}, 1'b1});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg  [DEPTH-1:0] ent_vld_reg;             // slot awaits downstream response
  reg  [DEPTH-1:0] ent_dev_reg;             // slot holds a device write
  reg  [AW-1:0]    ent_lo_reg [0:DEPTH-1];  // first byte of slot
  reg  [AW-1:0]    ent_hi_reg [0:DEPTH-1];  // last byte of slot
  reg  [QLOG2-1:0] wr_ptr_reg;              // push slot
  reg  [QLOG2-1:0] rd_ptr_reg;              // head slot
  reg  [QLOG2:0]   cnt_reg;                 // queued writes
  reg              late_pend_reg;           // a write waits for its real response
  reg  [NID-1:0]   mon_vld_reg;             // monitor armed per id
  reg  [AW-1:0]    mon_addr_reg [0:NID-1];  // monitored address per id
  reg              early_en_reg;            // software enable of early responses
  reg  [31:0]      stall_cnt_reg;           // cycles a read waited on a hazard
  reg  [1:0]       fs_reg;                  // issue state
  reg  [1:0]       rs_reg;                  // read state
  reg              hd_late_reg;             // head wants real response upstream
  reg              hd_excl_reg;             // head is a passed exclusive write
  reg  [ID_W-1:0]  hd_id_reg;               // head id
  reg              rd_lock_reg;             // current read is exclusive
  wire [EW-1:0]    q_rd;                    // head entry from store
  wire [EW-1:0]    q_wr;                    // entry being pushed
  wire [DEPTH-1:0] hit;                     // per-slot hazard for pending read
  wire [AW-1:0]    ar_hi;                   // last byte of pending read
  integer          i;

  ////////////////////////////////////////////////////////////////////////////
  // write acceptance decode
  wire wr_take  = s_awready & s_awvalid;
  wire mon_ok   = mon_vld_reg[s_awid] && (mon_addr_reg[s_awid] == s_awaddr);
  wire xfail    = s_awlock & ~mon_ok;
  wire is_early = s_awcache[`CACHE_BUF_BIT] & ~s_awlock & early_en_reg;
  wire push     = wr_take & ~xfail;
  wire pop      = (fs_reg == F_WAIT) & m_bvalid & m_bready;
  // capacity and any pending real response, whatever its id, gate acceptance
  wire wr_can   = s_awvalid & s_wvalid & ~s_awready & ~s_bvalid & ~late_pend_reg
                  & (cnt_reg != DEPTH[QLOG2:0]);
  assign q_wr = {~is_early, s_awlock, s_awid, s_awsize, s_awcache, s_wstrb, s_wdata, s_awaddr};

  ////////////////////////////////////////////////////////////////////////////
  // posted write store
  wq_mem #(
    .WIDTH (EW),
    .ALOG2 (QLOG2)
  ) u_store (
    .aclk  (aclk),
    .we    (push),
    .waddr (wr_ptr_reg),
    .wdata (q_wr),
    .raddr (rd_ptr_reg),
    .rdata (q_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // hazard compare of the pending read against every queued write
  assign ar_hi = last_byte(s_araddr, s_arsize);
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_hz
      assign hit[g] = ent_vld_reg[g] & (ent_dev_reg[g] ?
                      ((ent_lo_reg[g] >> REGION_SHIFT) == (s_araddr >> REGION_SHIFT)) :
                      ((ent_lo_reg[g] <= ar_hi) && (s_araddr <= ent_hi_reg[g])));
    end
  endgenerate
  // no read passes a buffered write it could observe
  wire rd_can = s_arvalid & ~s_arready & (rs_reg == R_IDLE) & ~(|hit) & ~s_awready;

  ////////////////////////////////////////////////////////////////////////////
  // queue bookkeeping
  always @(posedge aclk) begin
    if (!aresetn) begin
      ent_vld_reg   <= {DEPTH{1'b0}};
      ent_dev_reg   <= {DEPTH{1'b0}};
      wr_ptr_reg    <= {QLOG2{1'b0}};
      rd_ptr_reg    <= {QLOG2{1'b0}};
      cnt_reg       <= {(QLOG2+1){1'b0}};
      late_pend_reg <= 1'b0;
      s_awready     <= 1'b0;
      s_wready      <= 1'b0;
    end else begin
      // one-cycle ready pulse, address and data taken together
      s_awready <= wr_can;
      s_wready  <= wr_can;
      // slot stays valid until its downstream response
      if (pop) begin
        ent_vld_reg[rd_ptr_reg] <= 1'b0;
        rd_ptr_reg              <= rd_ptr_reg + {{(QLOG2-1){1'b0}}, 1'b1};
        if (hd_late_reg) begin
          late_pend_reg <= 1'b0;
        end
      end
      if (push) begin
        ent_vld_reg[wr_ptr_reg] <= 1'b1;
        ent_dev_reg[wr_ptr_reg] <= ~s_awcache[`CACHE_MOD_BIT];
        ent_lo_reg[wr_ptr_reg]  <= s_awaddr;
        ent_hi_reg[wr_ptr_reg]  <= last_byte(s_awaddr, s_awsize);
        wr_ptr_reg              <= wr_ptr_reg + {{(QLOG2-1){1'b0}}, 1'b1};
        if (!is_early) begin
          late_pend_reg <= 1'b1;
        end
      end
      // occupancy
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + {{QLOG2{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - {{QLOG2{1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upstream write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bid    <= {ID_W{1'b0}};
      s_bresp  <= `RESP_OKAY;
    end else if (wr_take & (is_early | xfail)) begin
      // early answer, or failed exclusive left unwritten
      s_bvalid <= 1'b1;
      s_bid    <= s_awid;
      s_bresp  <= `RESP_OKAY;
    end else if (pop & hd_late_reg) begin
      // real answer once the write reached its target
      s_bvalid <= 1'b1;
      s_bid    <= hd_id_reg;
      s_bresp  <= (hd_excl_reg && m_bresp == `RESP_OKAY) ? `RESP_EXOKAY : m_bresp;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // downstream issue, head forwarded as soon as it exists
  always @(posedge aclk) begin
    if (!aresetn) begin
      fs_reg      <= F_IDLE;
      m_awvalid   <= 1'b0;
      m_wvalid    <= 1'b0;
      m_bready    <= 1'b0;
      m_awid      <= {ID_W{1'b0}};
      m_awaddr    <= {AW{1'b0}};
      m_awsize    <= 3'h0;
      m_awcache   <= 4'h0;
      m_wdata     <= {DW{1'b0}};
      m_wstrb     <= {SW{1'b0}};
      hd_late_reg <= 1'b0;
      hd_excl_reg <= 1'b0;
      hd_id_reg   <= {ID_W{1'b0}};
    end else begin
      case (fs_reg)
        // wait for a queued write
        F_IDLE: begin
          if (cnt_reg != {(QLOG2+1){1'b0}}) begin
            fs_reg <= F_LOAD;
          end
        end
        // store output now holds the head; whole beat sent unsplit
        F_LOAD: begin
          m_awvalid   <= 1'b1;
          m_wvalid    <= 1'b1;
          m_awaddr    <= q_rd[AW-1:0];
          m_wdata     <= q_rd[O_S-1:O_D];
          m_wstrb     <= q_rd[O_C-1:O_S];
          m_awcache   <= q_rd[O_Z-1:O_C];
          m_awsize    <= q_rd[O_I-1:O_Z];
          m_awid      <= q_rd[O_X-1:O_I];
          hd_id_reg   <= q_rd[O_X-1:O_I];
          hd_excl_reg <= q_rd[O_X];
          hd_late_reg <= q_rd[O_L];
          fs_reg      <= F_SEND;
        end
        // address and data may be taken in either order
        F_SEND: begin
          if (m_awready) begin
            m_awvalid <= 1'b0;
          end
          if (m_wready) begin
            m_wvalid <= 1'b0;
          end
          if ((m_awready | ~m_awvalid) & (m_wready | ~m_wvalid)) begin
            m_bready <= 1'b1;
            fs_reg   <= F_WAIT;
          end
        end
        // stored copy released only on the downstream answer
        F_WAIT: begin
          if (m_bvalid) begin
            m_bready <= 1'b0;
            fs_reg   <= F_IDLE;
          end
        end
        default: begin
          fs_reg <= F_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exclusive monitor, one address per id
  always @(posedge aclk) begin
    if (!aresetn) begin
      mon_vld_reg <= {NID{1'b0}};
    end else begin
      // any write that goes ahead disarms watchers of its address
      for (i = 0; i < NID; i = i + 1) begin
        if (push && mon_addr_reg[i] == s_awaddr) begin
          mon_vld_reg[i] <= 1'b0;
        end
      end
      // new exclusive read replaces the address, arming wins
      if (s_arready & s_arvalid & s_arlock) begin
        mon_vld_reg[s_arid]  <= 1'b1;
        mon_addr_reg[s_arid] <= s_araddr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, one read at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      rs_reg        <= R_IDLE;
      s_arready     <= 1'b0;
      m_arvalid     <= 1'b0;
      m_rready      <= 1'b0;
      m_arid        <= {ID_W{1'b0}};
      m_araddr      <= {AW{1'b0}};
      m_arsize      <= 3'h0;
      m_arcache     <= 4'h0;
      s_rvalid      <= 1'b0;
      s_rid         <= {ID_W{1'b0}};
      s_rdata       <= {DW{1'b0}};
      s_rresp       <= `RESP_OKAY;
      s_rlast       <= 1'b0;
      rd_lock_reg   <= 1'b0;
      stall_cnt_reg <= 32'h0;
    end else begin
      s_arready <= rd_can;
      // count cycles lost to write hazards
      if (s_arvalid & (rs_reg == R_IDLE) & (|hit)) begin
        stall_cnt_reg <= stall_cnt_reg + 32'h1;
      end else if (cfg_awready & cfg_awvalid & (cfg_awaddr == `STALL_OFF)) begin
        stall_cnt_reg <= 32'h0;
      end
      case (rs_reg)
        // take the address
        R_IDLE: begin
          if (s_arready & s_arvalid) begin
            m_arvalid   <= 1'b1;
            m_arid      <= s_arid;
            m_araddr    <= s_araddr;
            m_arsize    <= s_arsize;
            m_arcache   <= s_arcache;
            rd_lock_reg <= s_arlock;
            rs_reg      <= R_ADDR;
          end
        end
        // forward it
        R_ADDR: begin
          if (m_arready) begin
            m_arvalid <= 1'b0;
            m_rready  <= 1'b1;
            rs_reg    <= R_DATA;
          end
        end
        // catch the data
        R_DATA: begin
          if (m_rvalid) begin
            m_rready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rid    <= m_arid;
            s_rdata  <= m_rdata;
            s_rlast  <= 1'b1;
            s_rresp  <= (rd_lock_reg && m_rresp == `RESP_OKAY) ? `RESP_EXOKAY : m_rresp;
            rs_reg   <= R_RESP;
          end
        end
        // hand it upstream
        R_RESP: begin
          if (s_rready) begin
            s_rvalid <= 1'b0;
            s_rlast  <= 1'b0;
            rs_reg   <= R_IDLE;
          end
        end
        default: begin
          rs_reg <= R_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration bus slave
  wire [31:0] stat_word = ({{(31-QLOG2){1'b0}}, cnt_reg} << `STAT_CNT_LSB)
                        | ({31'h0, late_pend_reg} << `STAT_LATE_BIT)
                        | ({31'h0, OWO[0]} << `STAT_OWO_BIT)
                        | ({31'h0, `MCA_VAL} << `STAT_MCA_BIT)
                        | ({31'h0, fs_reg != F_IDLE} << `STAT_BUSY_BIT);
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_awready  <= 1'b0;
      cfg_wready   <= 1'b0;
      cfg_bvalid   <= 1'b0;
      cfg_bresp    <= `RESP_OKAY;
      cfg_arready  <= 1'b0;
      cfg_rvalid   <= 1'b0;
      cfg_rdata    <= 32'h0;
      cfg_rresp    <= `RESP_OKAY;
      early_en_reg <= `CTRL_RST;
    end else begin
      // write: address and data together, one at a time
      cfg_awready <= cfg_awvalid & cfg_wvalid & ~cfg_awready & ~cfg_bvalid;
      cfg_wready  <= cfg_awvalid & cfg_wvalid & ~cfg_awready & ~cfg_bvalid;
      if (cfg_awready & cfg_awvalid) begin
        cfg_bvalid <= 1'b1;
        cfg_bresp  <= `RESP_OKAY;
        if (cfg_awaddr == `CTRL_OFF) begin
          if (cfg_wstrb[0]) begin
            early_en_reg <= cfg_wdata[`CTRL_EARLY_BIT];
          end
        end else if (cfg_awaddr != `STAT_OFF && cfg_awaddr != `STALL_OFF) begin
          cfg_bresp <= `RESP_DECERR;
        end
      end else if (cfg_bready) begin
        cfg_bvalid <= 1'b0;
      end
      // read
      cfg_arready <= cfg_arvalid & ~cfg_arready & ~cfg_rvalid;
      if (cfg_arready & cfg_arvalid) begin
        cfg_rvalid <= 1'b1;
        cfg_rresp  <= `RESP_OKAY;
        case (cfg_araddr)
          `CTRL_OFF:  cfg_rdata <= {31'h0, early_en_reg};
          `STAT_OFF:  cfg_rdata <= stat_word;
          `STALL_OFF: cfg_rdata <= stall_cnt_reg;
          default: begin
            cfg_rdata <= 32'h0;
            cfg_rresp <= `RESP_DECERR;
          end
        endcase
      end else if (cfg_rready) begin
        cfg_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: verif/early_wr_buffer_asserts.sv
`timescale 1ns/100ps
////////////////////////////////////////
// watches the buffer ports for response and ordering slips
module ewr_chk (
  input logic        aclk, aresetn, s_awready, s_awlock, s_bvalid, m_bvalid, m_bready,
  input logic        m_awvalid, m_awready, s_arready, s_arlock, s_rvalid, m_arvalid,
  input logic [3:0]  s_awcache,
  input logic [31:0] s_awaddr, s_araddr,
  input logic [1:0]  s_bresp, s_rresp
);
  logic        wl, rl, hz; // lock of last write, of last read, early write pending
  logic [29:0] ha;         // word address of last early write
  // remember what the last takes asked for
  always @(posedge aclk) begin
    if (!aresetn) begin
      {wl, rl, hz, ha} <= 0;
    end else begin
      if (s_awready) wl <= s_awlock;
      if (s_arready) rl <= s_arlock;
      if (m_bvalid && m_bready) hz <= 0;
      if (s_awready && s_awcache[0] && !s_awlock) begin
        hz <= 1;
        ha <= s_awaddr[31:2];
      end
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  no_early_late_a:
    assert property (s_awready && !s_awcache[0] && !s_awlock |=> !s_bvalid)
    else $error("early reply to plain write");
  resp_cause_a:
    assert property ($rose(s_bvalid) |-> $past(s_awready) || $past(m_bvalid && m_bready))
    else $error("write reply without cause");
  fwd_bound_a:
    assert property (s_awready && s_awcache[0] && !s_awlock |-> ##[1:200] m_awvalid)
    else $error("posted write not forwarded");
  aw_hold_a:
    assert property (m_awvalid && !m_awready |=> m_awvalid) else $error("forwarded write dropped");
  exok_wr_a:
    assert property ($rose(s_bvalid) && !wl |-> s_bresp != 2'h1) else $error("exokay on normal write");
  exok_rd_a:
    assert property (s_rvalid && !rl |-> s_rresp != 2'h1) else $error("exokay on normal read");
  read_hazard_a:
    assert property (s_arready |-> !(hz && s_araddr[31:2] == ha)) else $error("read passed pending write");
  ar_fwd_a:
    assert property (s_arready |=> m_arvalid) else $error("read not forwarded");
endmodule

// File: verif/ewr_slave_model.sv
`timescale 1ns/100ps
////////////////////////////////////////
// downstream memory slave, prompt, slow or stalled
module ewr_slave_model (
  input  logic        aclk, aresetn,
  input  logic [1:0]  mode, // 0 prompt, 1 slow, 2 stalled
  input  logic        m_awvalid, m_wvalid, m_bready, m_arvalid, m_rready,
  input  logic [31:0] m_awaddr, m_wdata, m_araddr,
  output logic        m_awready, m_wready, m_bvalid, m_arready, m_rvalid,
  output logic [31:0] m_rdata,
  output logic [1:0]  m_bresp, m_rresp
);
  logic [31:0] mem [16]; // word store
  logic [31:0] wd;       // taken write data
  logic [3:0]  wa;       // taken write word
  logic [1:0]  cnt;      // slow-mode divider
  logic        ga, gw;   // address and data taken
  wire         g = mode == 0 || (mode == 1 && cnt == 3);
  assign m_bresp = 2'h0;
  assign m_rresp = 2'h0;
  // one write at a time, read addresses taken even while read data is held; readies pulse when gated
  always @(posedge aclk) begin
    cnt <= cnt + 2'h1;
    if (!aresetn) begin
      {m_awready, m_wready, m_bvalid, m_arready, m_rvalid, ga, gw, cnt} <= 0;
      m_rdata <= 32'h0;
    end else begin
      m_awready <= m_awvalid && !m_awready && !ga && g;
      m_wready <= m_wvalid && !m_wready && !gw && g;
      m_arready <= m_arvalid && !m_arready && g;
      if (m_awvalid && m_awready) {ga, wa} <= {1'b1, m_awaddr[5:2]};
      if (m_wvalid && m_wready) {gw, wd} <= {1'b1, m_wdata};
      if (ga && gw && !m_bvalid && g) begin
        mem[wa] <= wd;
        {m_bvalid, ga, gw} <= 3'h4;
      end
      if (m_bvalid && m_bready) m_bvalid <= 0;
      if (m_arvalid && m_arready) {m_rvalid, m_rdata} <= {1'b1, mem[m_araddr[5:2]]};
      // released data shows the inverse, never the last value
      if (m_rvalid && m_rready) {m_rvalid, m_rdata} <= {1'b0, ~m_rdata};
    end
  end
endmodule

// File: verif/axi_early_write_response_buffer_bench.sv
`timescale 1ns/100ps
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("BAD %0t got %h want %h", $time, a, b); end end
////////////////////////////////////////
module axi_early_write_response_buffer_bench;
  logic aclk = 0, aresetn = 0, s_awvalid = 0, s_awlock = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_arlock = 0;
  logic s_rready = 0, cfg_awvalid = 0, cfg_wvalid = 0, cfg_bready = 0, cfg_arvalid = 0, cfg_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, s_rlast, m_awvalid, m_awready, m_wvalid, m_wready;
  logic m_bvalid, m_bready, m_arvalid, m_arready, m_rvalid, m_rready, cfg_awready, cfg_wready, cfg_bvalid;
  logic cfg_arready, cfg_rvalid;
  logic [3:0]  s_awid = 0, s_arid = 0, s_awcache = 0, s_arcache = 0, s_wstrb = 4'hF, cfg_wstrb = 4'hF;
  logic [3:0]  s_bid, s_rid, m_awid, m_arid, m_awcache, m_arcache, m_wstrb;
  logic [31:0] s_awaddr = 0, s_araddr = 0, s_wdata = 0, cfg_wdata = 0;
  logic [31:0] s_rdata, m_awaddr, m_wdata, m_araddr, m_rdata, cfg_rdata, d;
  logic [2:0]  s_awsize = 3'h2, s_arsize = 3'h2, m_awsize, m_arsize;
  logic [1:0]  s_bresp, s_rresp, m_bresp, m_rresp, cfg_bresp, cfg_rresp, r, mode = 0;
  logic [7:0]  cfg_awaddr = 0, cfg_araddr = 0;
  int          err_total = 0, cmp_count = 0, cyc = 0, n;
  // cache code, address, data; early reply expected when cache bit 0 set
  logic [67:0] rows [4] = '{{4'h0, 32'h10, 32'hA0}, {4'h1, 32'h14, 32'hA1},
                            {4'h2, 32'h18, 32'hA2}, {4'h3, 32'h1C, 32'hA3}};
  early_wr_buffer dut (.*);
  ewr_slave_model pm (.*);
  always #5 aclk = ~aclk;
  ////////////////////////////////////////
  // one upstream write, n counts cycles from take to reply
  task automatic wr(input [3:0] id, c, input l, input [31:0] a, v, output [1:0] rs, output int k);
    {s_awid, s_awcache, s_awlock, s_awaddr, s_wdata} <= {id, c, l, a, v};
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    do @(posedge aclk); while (!s_awready);
    {s_awvalid, s_wvalid} <= 2'h0;
    k = 0;
    do begin @(posedge aclk); k++; end while (!s_bvalid);
    rs = s_bresp;
    `CK(s_bid, id)
    s_bready <= 0;
    @(posedge aclk);
  endtask
  // one upstream read
  task automatic rd(input [3:0] id, input l, input [31:0] a, output [31:0] v, output [1:0] rs);
    {s_arid, s_arlock, s_araddr, s_arcache, s_arvalid, s_rready} <= {id, l, a, 4'h2, 2'h3};
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 0;
    do @(posedge aclk); while (!s_rvalid);
    {v, rs} = {s_rdata, s_rresp};
    `CK(s_rid, id)
    `CK(s_rlast, 1'b1)
    s_rready <= 0;
    @(posedge aclk);
  endtask
  // configuration access, w selects write
  task automatic cfg(input w, input [7:0] a, input [31:0] wv, output [31:0] v, output [1:0] rs);
    logic [1:0] p; // address and data still on offer
    if (w) begin
      {cfg_awaddr, cfg_wdata, cfg_awvalid, cfg_wvalid, cfg_bready} <= {a, wv, 3'h7};
      p = 2'h3;
      // each channel released at the edge that takes it
      while (p != 2'h0) begin
        @(posedge aclk);
        if (cfg_awready) p[1] = 1'b0;
        if (cfg_wready) p[0] = 1'b0;
        {cfg_awvalid, cfg_wvalid} <= p;
      end
      do @(posedge aclk); while (!cfg_bvalid);
      rs = cfg_bresp;
      cfg_bready <= 0;
    end else begin
      {cfg_araddr, cfg_arvalid, cfg_rready} <= {a, 2'h3};
      do @(posedge aclk); while (!cfg_arready);
      cfg_arvalid <= 0;
      do @(posedge aclk); while (!cfg_rvalid);
      {v, rs} = {cfg_rdata, cfg_rresp};
      cfg_rready <= 0;
    end
    @(posedge aclk);
  endtask
  task tally_and_finish;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    cfg(0, 8'h00, 0, d, r); `CK(d, 32'h1)
    cfg(0, 8'h04, 0, d, r); `CK(d, 32'h400)
    cfg(0, 8'h0C, 0, d, r); `CK(r, 2'h3)
    mode <= 1;
    foreach (rows[i]) begin
      wr(4'h1, rows[i][67:64], 0, rows[i][63:32], rows[i][31:0], r, n);
      `CK(n == 1, rows[i][64])
      rd(4'h1, 0, rows[i][63:32], d, r); `CK(d, rows[i][31:0])
    end
    cfg(1, 8'h00, 0, d, r);
    wr(1, 3, 0, 32'h20, 32'hB0, r, n); `CK(n > 1, 1'b1)
    cfg(1, 8'h00, 1, d, r);
    mode <= 2;
    for (int i = 0; i < 4; i++) begin
      wr(2, 3, 0, 32'h24, i, r, n); `CK(n == 1, 1'b1)
    end
    cfg(0, 8'h04, 0, d, r); `CK(d[2:0], 3'h4)
    mode <= 1;
    rd(2, 0, 32'h24, d, r); `CK(d, 32'h3)
    cfg(0, 8'h08, 0, d, r); `CK(d != 0, 1'b1)
    cfg(1, 8'h08, 0, d, r);
    cfg(0, 8'h08, 0, d, r); `CK(d, 32'h0)
    rd(3, 1, 32'h28, d, r); `CK(r, 2'h1)
    wr(3, 2, 1, 32'h28, 32'hC1, r, n); `CK(r, 2'h1)
    rd(3, 1, 32'h28, d, r);
    wr(5, 3, 0, 32'h28, 32'hC2, r, n);
    wr(3, 2, 1, 32'h28, 32'hC3, r, n); `CK(r, 2'h0)
    rd(3, 0, 32'h28, d, r); `CK(d, 32'hC2)
    rd(4, 1, 32'h2C, d, r);
    rd(4, 1, 32'h30, d, r);
    wr(4, 2, 1, 32'h2C, 32'hD1, r, n); `CK(r, 2'h0)
    wr(4, 2, 1, 32'h30, 32'hD2, r, n); `CK(r, 2'h1)
    cfg(1, 8'h00, 0, d, r); `CK(r, 2'h0)
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    cfg(0, 8'h00, 0, d, r); `CK(d, 32'h1)
    cfg(0, 8'h04, 0, d, r); `CK(d, 32'h400)
    tally_and_finish;
  end
endmodule
bind early_wr_buffer ewr_chk chk (.*);
